// File: bmbil_top.sv
// Byte-lane mask and bus-inversion logic with AHB-Lite configuration
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module bmbil_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire bmbil_pkg::bmbil_op_type CMD_OP,
  input wire logic BEAT_IN,
  input wire logic [15:0] DQ_IN,
  output logic [15:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic [1:0] MASK_INVERT_LANE_PIN_IN,
  output logic [1:0] MASK_INVERT_LANE_PIN_OUT,
  output logic [1:0] MASK_INVERT_LANE_PIN_OE,
  output logic PIN_RX_EN,
  output bmbil_pkg::bmbil_beat_type ARR_BEAT,
  output logic ARR_VALID,
  input wire logic ARR_READY,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_VALID,
  output logic RD_READY
);

  // ****************************************
  // Register bus (AHB-Lite slave)
  // ****************************************
  logic [31:0] mode3_r;
  logic [31:0] mode13_r;
  logic [31:0] calpat_r;
  logic [1:0] status_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;

  wire addr_ph = HSEL && HREADY && HTRANS[1];
  wire [7:0] a_ofs = HADDR[7:0];
  wire hit_mode3 = wr_pend_r && (wr_addr_r == bmbil_pkg::MODE3_OFS);
  wire hit_mode13 = wr_pend_r && (wr_addr_r == bmbil_pkg::MODE13_OFS);
  wire hit_cal = wr_pend_r && (wr_addr_r == bmbil_pkg::CALPAT_OFS);
  wire hit_stat = wr_pend_r && (wr_addr_r == bmbil_pkg::STATUS_OFS);

  // Zero wait states, always OKAY; unmapped words read zero
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_r;

  // Read mux, selected in the address phase
  always_comb begin
    unique case (a_ofs)
      bmbil_pkg::MODE3_OFS: rd_mux = mode3_r;
      bmbil_pkg::MODE13_OFS: rd_mux = mode13_r;
      bmbil_pkg::CALPAT_OFS: rd_mux = calpat_r;
      bmbil_pkg::STATUS_OFS: rd_mux = {30'h0000_0000, status_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Address phase capture, read data loaded ahead of the data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && HWRITE;
      if (addr_ph) wr_addr_r <= a_ofs;
      if (addr_ph && !HWRITE) hrdata_r <= rd_mux;
    end
  end

  // Mode images: only the documented bits are kept
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode3_r <= bmbil_pkg::MODE3_RST;
      mode13_r <= bmbil_pkg::MODE13_RST;
      calpat_r <= bmbil_pkg::CALPAT_RST;
    end else begin
      if (hit_mode3) mode3_r <= HWDATA & 32'h0000_00C0;
      if (hit_mode13) mode13_r <= HWDATA & 32'h0000_0020;
      if (hit_cal) calpat_r <= {16'h0000, HWDATA[15:0]};
    end
  end

  // Function enables
  wire rd_inv_en = mode3_r[bmbil_pkg::RD_INV_BIT];
  wire wr_inv_en = mode3_r[bmbil_pkg::WR_INV_BIT];
  wire mask_en = !mode13_r[bmbil_pkg::MASK_DIS_BIT];
  wire any_en = rd_inv_en || wr_inv_en || mask_en;

  // ****************************************
  // Pin capture
  // ****************************************
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic beat_s1_r;
  logic beat_s2_r;

  // Two-flop capture; pin and data share one beat strobe
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      pin_s1_r <= 2'b00;
      pin_s2_r <= 2'b00;
      beat_s1_r <= 1'b0;
      beat_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= DQ_IN;
      dq_s2_r <= dq_s1_r;
      pin_s1_r <= MASK_INVERT_LANE_PIN_IN;
      pin_s2_r <= pin_s1_r;
      beat_s1_r <= BEAT_IN;
      beat_s2_r <= beat_s1_r;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  wire op_wr = (CMD_OP == bmbil_pkg::OP_WRITE);
  wire op_mw = (CMD_OP == bmbil_pkg::OP_MWRITE);
  wire op_mrw = (CMD_OP == bmbil_pkg::OP_MRW);
  wire op_wf = (CMD_OP == bmbil_pkg::OP_WFIFO);
  wire op_rd = (CMD_OP == bmbil_pkg::OP_READ);
  wire op_mrr = (CMD_OP == bmbil_pkg::OP_MRR);
  wire op_rf = (CMD_OP == bmbil_pkg::OP_RFIFO);
  wire op_cal = (CMD_OP == bmbil_pkg::OP_DQCAL);
  wire op_wtype = op_wr || op_mw || op_mrw || op_wf;
  wire op_rtype = op_rd || op_mrr || op_rf || op_cal;

  // Receivers on for write, MRW and masked-write beats when write inversion or masking is on, and for write-FIFO beats when any function is
  wire rx_wr = (op_wr || op_mrw || op_mw) && (wr_inv_en || mask_en);
  assign PIN_RX_EN = rx_wr || (op_wf && any_en);
  wire [1:0] pin_g = pin_s2_r & {2{PIN_RX_EN}};

  wire illegal_mw = op_mw && !mask_en;
  wire beat_wr = beat_s2_r && op_wtype && !illegal_mw;
  logic buf_in_ready;
  bmbil_pkg::bmbil_beat_type in_beat;

  // Per-lane write decision; each beat judged on its own
  generate
    for (genvar ln = 0; ln < bmbil_pkg::LANES; ln++) begin : g_wlane
      wire [7:0] b = dq_s2_r[8*ln +: 8];
      wire [3:0] hi6 = bmbil_pkg::bmbil_ones8({b[7:2], 2'b00});
      wire inv_on = wr_inv_en && (op_wr || op_mrw || op_mw);
      wire do_inv = inv_on && pin_g[ln];
      wire m_plain = op_mw && mask_en && !wr_inv_en && pin_g[ln];
      wire m_code = op_mw && mask_en && wr_inv_en && !pin_g[ln]
                    && (hi6 >= bmbil_pkg::MASK_LIMIT);
      // Plain writes, MRW and training never mask
      assign in_beat.data[8*ln +: 8] = do_inv ? ~b : b;
      assign in_beat.keep[ln] = !(m_plain || m_code);
    end
  endgenerate

  // Beat buffer toward the array; full buffer drops and flags the beat
  bmbil_skid #(
    .W($bits(bmbil_pkg::bmbil_beat_type)),
    .D(bmbil_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(CLK),
    .rst_n(RSTN),
    .in_data(in_beat),
    .in_valid(beat_wr),
    .in_ready(buf_in_ready),
    .out_data(ARR_BEAT),
    .out_valid(ARR_VALID),
    .out_ready(ARR_READY)
  );

  // ****************************************
  // Training pattern store
  // ****************************************
  logic [1:0] train_mem [bmbil_pkg::TRAIN_DEPTH];
  logic [bmbil_pkg::TRAIN_AW-1:0] tw_ptr_r;
  logic [bmbil_pkg::TRAIN_AW-1:0] tr_ptr_r;
  logic [bmbil_pkg::TRAIN_AW-1:0] cal_ptr_r;
  wire train_cap = beat_s2_r && op_wf && any_en;
  wire rd_fire = RD_VALID && op_rtype;
  wire rf_step = rd_fire && op_rf;
  wire cal_step = rd_fire && op_cal;

  // Pattern captured per write-FIFO beat
  always_ff @(posedge CLK) begin
    if (train_cap) begin
      train_mem[tw_ptr_r] <= pin_g;
    end
  end

  // Training pointers step once per beat
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tw_ptr_r <= '0;
      tr_ptr_r <= '0;
      cal_ptr_r <= '0;
    end else begin
      if (train_cap) tw_ptr_r <= tw_ptr_r + 1'b1;
      if (rf_step) tr_ptr_r <= tr_ptr_r + 1'b1;
      if (cal_step) cal_ptr_r <= cal_ptr_r + 1'b1;
    end
  end

  // ****************************************
  // Read encode
  // ****************************************
  logic [15:0] rd_dq;
  logic [1:0] rd_pin;
  wire rd_code = rd_inv_en && (op_rd || op_mrr);
  wire [1:0] rf_pat = train_mem[tr_ptr_r];
  wire [1:0] cal_pat = calpat_r[2*cal_ptr_r +: 2];
  wire pin_drive = rd_code || ((op_rf || op_cal) && any_en);

  // Array data taken whenever a read-type beat is under way
  assign RD_READY = op_rtype;

  generate
    for (genvar ln = 0; ln < bmbil_pkg::LANES; ln++) begin : g_rlane
      wire [7:0] b = RD_DATA[8*ln +: 8];
      wire heavy = bmbil_pkg::bmbil_ones8(b) > bmbil_pkg::RD_INV_LIMIT;
      wire inv = rd_code && heavy;
      assign rd_dq[8*ln +: 8] = inv ? ~b : b;
      assign rd_pin[ln] = op_rf ? rf_pat[ln] :
                          op_cal ? cal_pat[ln] : inv;
    end
  endgenerate

  logic [15:0] dq_out_r;
  logic [1:0] pin_out_r;
  logic dq_oe_r;
  logic pin_oe_r;

  // Output stage registered; drivers released between beats
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_out_r <= 16'h0000;
      pin_out_r <= 2'b00;
      dq_oe_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      dq_oe_r <= rd_fire;
      pin_oe_r <= rd_fire && pin_drive;
      if (rd_fire) dq_out_r <= rd_dq;
      pin_out_r <= (rd_fire && pin_drive) ? rd_pin : 2'b00;
    end
  end

  assign DQ_OUT = dq_out_r;
  assign DQ_OE = dq_oe_r;
  assign MASK_INVERT_LANE_PIN_OUT = pin_out_r;
  assign MASK_INVERT_LANE_PIN_OE = {2{pin_oe_r}};

  // ****************************************
  // Status: set wins over write-one-to-clear
  // ****************************************
  wire set_ill = beat_s2_r && illegal_mw;
  wire set_drop = beat_wr && !buf_in_ready;
  wire [1:0] st_set = {set_drop, set_ill};
  wire [1:0] st_clr = hit_stat ? HWDATA[1:0] : 2'b00;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_r <= 2'b00;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_rd_heavy0;
    rd_fire && rd_code && (bmbil_pkg::bmbil_ones8(RD_DATA[7:0]) > 4'h4);
  endsequence

  sequence s_rd_light0;
    rd_fire && rd_code && (bmbil_pkg::bmbil_ones8(RD_DATA[7:0]) <= 4'h4);
  endsequence

  AST_RD_INV: assert property (@(posedge CLK) disable iff (!RSTN)
    s_rd_heavy0 |=> pin_out_r[0] && pin_oe_r
      && (dq_out_r[7:0] == ~$past(RD_DATA[7:0])))
    else $error("heavy read byte not inverted");

  AST_RD_PLAIN: assert property (@(posedge CLK) disable iff (!RSTN)
    s_rd_light0 |=> !pin_out_r[0] && (dq_out_r[7:0] == $past(RD_DATA[7:0])))
    else $error("light read byte altered");

  AST_RD_HIZ: assert property (@(posedge CLK) disable iff (!RSTN)
    (!rd_inv_en && (op_rd || op_mrr)) |=> !pin_oe_r)
    else $error("pin driven with read inversion off");

  AST_TRAIN_HIZ: assert property (@(posedge CLK) disable iff (!RSTN)
    (!any_en && op_rtype) |=> (MASK_INVERT_LANE_PIN_OE == 2'b00))
    else $error("pin driven with all functions off");

  AST_WR_INV: assert property (@(posedge CLK) disable iff (!RSTN)
    (beat_wr && op_wr && wr_inv_en && pin_s2_r[1])
      |-> (in_beat.data[15:8] == ~dq_s2_r[15:8]))
    else $error("upper byte not inverted on write");

  AST_NO_MASK_WR: assert property (@(posedge CLK)
    disable iff (!RSTN)
    (beat_wr && (op_wr || op_mrw)) |-> (in_beat.keep == 2'b11))
    else $error("plain write masked a byte");

  AST_MW_PLAIN: assert property (@(posedge CLK) disable iff (!RSTN)
    (beat_wr && op_mw && !wr_inv_en) |-> (in_beat.keep == ~pin_s2_r))
    else $error("mask does not follow pin");

  AST_MW_CODE: assert property (@(posedge CLK) disable iff (!RSTN)
    (beat_wr && op_mw && wr_inv_en && !pin_s2_r[0]
      && (bmbil_pkg::bmbil_ones8({dq_s2_r[7:2], 2'b00}) >= 4'h5))
      |-> !in_beat.keep[0])
    else $error("coded mask beat was written");

  AST_RX_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    ((op_wr || op_mw || op_mrw || (op_wf && !any_en)) && !wr_inv_en
      && !mask_en) |-> !PIN_RX_EN && (pin_g == 2'b00))
    else $error("receivers on with functions off");

  AST_WF_TRAIN: assert property (@(posedge CLK) disable iff (!RSTN)
    (train_cap && buf_in_ready) |=> ARR_VALID
      && (train_mem[$past(tw_ptr_r)] == $past(pin_s2_r)))
    else $error("training pattern not captured");

endmodule : bmbil_top

// File: bmbil_pkg.sv
// Shared constants, types and helpers for the mask/inversion lane block
package bmbil_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] MODE3_OFS = 8'h00;
  localparam logic [7:0] MODE13_OFS = 8'h04;
  localparam logic [7:0] CALPAT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [31:0] MODE3_RST = 32'h0000_0000;
  localparam logic [31:0] MODE13_RST = 32'h0000_0000;
  localparam logic [31:0] CALPAT_RST = 32'h0000_5A3C;
  localparam int RD_INV_BIT = 6;
  localparam int WR_INV_BIT = 7;
  localparam int MASK_DIS_BIT = 5;
  localparam int ST_ILLEGAL_BIT = 0;
  localparam int ST_DROP_BIT = 1;

  // ****************************************
  // Lane geometry and thresholds
  // ****************************************
  localparam int LANES = 2;
  localparam int TRAIN_DEPTH = 8;
  localparam int TRAIN_AW = 3;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] RD_INV_LIMIT = 4'h4;
  localparam logic [3:0] MASK_LIMIT = 4'h5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_WRITE = 4'b0001,
    OP_MWRITE = 4'b0010,
    OP_MRW = 4'b0011,
    OP_READ = 4'b0100,
    OP_MRR = 4'b0101,
    OP_WFIFO = 4'b0110,
    OP_RFIFO = 4'b0111,
    OP_DQCAL = 4'b1000
  } bmbil_op_type;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] keep;
  } bmbil_beat_type;

  // Count of ones in a byte
  function automatic logic [3:0] bmbil_ones8(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, b[i]};
    end
    return n;
  endfunction : bmbil_ones8

endpackage : bmbil_pkg

// File: bmbil_skid.sv
// Two-entry beat buffer with valid/ready on both sides
`timescale 1ns/1ps
module bmbil_skid #(
  parameter int W = 18,
  parameter int D = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come straight from the fill count
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rptr_r];

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + 1'b1;
      if (pop) rptr_r <= rptr_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : bmbil_skid

// File: bmbil_host_model.sv
// Host controller model driving write beats and command codes
`timescale 1ns/1ps
module bmbil_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire bmbil_pkg::bmbil_op_type op,
  input wire logic [15:0] data,
  input wire logic [1:0] pin,
  input wire logic wr_inv,
  input wire bmbil_pkg::bmbil_op_type rd_op,
  output logic beat,
  output logic [15:0] dq,
  output logic [1:0] pin_o,
  output bmbil_pkg::bmbil_op_type cmd_op
);
  // ****************************************
  // Beat pipeline
  // ****************************************
  bmbil_pkg::bmbil_op_type op1_r, op2_r, op3_r;
  logic b2_r, b3_r;
  // Code trails its beat by two edges, matching the lane synchroniser
  assign cmd_op = b3_r ? op3_r : rd_op;
  // Idle lanes toggle so a stale value never passes for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beat <= 1'b0;
      b2_r <= 1'b0;
      b3_r <= 1'b0;
      op1_r <= bmbil_pkg::OP_NONE;
      op2_r <= bmbil_pkg::OP_NONE;
      op3_r <= bmbil_pkg::OP_NONE;
      dq <= 16'h0000;
      pin_o <= 2'b00;
    end else begin
      beat <= req;
      b2_r <= beat;
      b3_r <= b2_r;
      op1_r <= op;
      op2_r <= op1_r;
      op3_r <= op2_r;
      dq <= req ? data : ~dq;
      pin_o <= !req ? ~pin_o : (op == bmbil_pkg::OP_WRITE && !wr_inv) ?
               2'b00 : pin;
    end
  end
endmodule : bmbil_host_model

// File: tb_byte_mask_bus_inversion_lane.sv
// Self-checking bench for the mask/inversion lane block
`timescale 1ns/1ps
module tb_byte_mask_bus_inversion_lane;
  logic CLK, RSTN, HSEL, HWRITE, h_req, RD_VALID, stall, train;
  logic ri, wi, md, rx_en, DQ_OE, HREADYOUT, HRESP, RD_READY, ARR_VALID;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, h_p, pin_host, PIN_OUT, PIN_OE, pin_w;
  logic [2:0] HSIZE;
  logic [15:0] h_d, dq_host, DQ_OUT, dq_w, RD_DATA, cp;
  logic ARR_READY, beat;
  bmbil_pkg::bmbil_op_type h_op, rd_op, cmd;
  bmbil_pkg::bmbil_beat_type ARR_BEAT;
  logic [33:0] expq[$];
  logic [1:0] tq[$];
  int err_count, total_checks, cyc, ci;
  // Shared wires: whoever enables drives
  assign pin_w[0] = PIN_OE[0] ? PIN_OUT[0] : pin_host[0];
  assign pin_w[1] = PIN_OE[1] ? PIN_OUT[1] : pin_host[1];
  assign dq_w = DQ_OE ? DQ_OUT : dq_host;
  bmbil_top i_bmbil_top (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMD_OP(cmd), .BEAT_IN(beat),
    .DQ_IN(dq_w), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .MASK_INVERT_LANE_PIN_IN(pin_w), .MASK_INVERT_LANE_PIN_OUT(PIN_OUT),
    .MASK_INVERT_LANE_PIN_OE(PIN_OE), .PIN_RX_EN(rx_en),
    .ARR_BEAT(ARR_BEAT), .ARR_VALID(ARR_VALID), .ARR_READY(ARR_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY));
  bmbil_host_model i_bmbil_host_model (.clk(CLK), .rst_n(RSTN),
    .req(h_req), .op(h_op), .data(h_d), .pin(h_p), .wr_inv(wi),
    .rd_op(rd_op), .beat(beat), .dq(dq_host), .pin_o(pin_host),
    .cmd_op(cmd));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic int ones(logic [7:0] b);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) n += b[i];
    return n;
  endfunction : ones
  // Expected {compare mask, data, keep} of one write beat
  function automatic logic [33:0] wexp(bmbil_pkg::bmbil_op_type op,
                                       logic [15:0] d, logic [1:0] p);
    logic [15:0] o, m;
    logic [1:0] k;
    logic mw;
    o = d;
    m = 16'hFFFF;
    k = 2'b11;
    mw = (op == bmbil_pkg::OP_MWRITE);
    for (int l = 0; l < 2; l++) begin
      if (mw && !wi) k[l] = ~p[l];
      else if (mw && !p[l] && ones({2'b00, d[8*l+2 +: 6]}) >= 5) k[l] = 0;
      else if (wi && p[l]) o[8*l +: 8] = ~d[8*l +: 8];
      if (!k[l]) m[8*l +: 8] = 8'h00;
    end
    return {m, o & m, k};
  endfunction : wexp
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // One AHB-Lite single word transfer; waits on hready each phase
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= {24'h00_0000, a};
    HTRANS <= 2'b10;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    chk(HRESP, 0);
  endtask : ahb
  task automatic setm(logic r, logic w, logic m);
    ri = r;
    wi = w;
    md = m;
    ahb(1, bmbil_pkg::MODE3_OFS, {24'h00_0000, w, r, 6'h00});
    ahb(1, bmbil_pkg::MODE13_OFS, {26'h000_0000, m, 5'h00});
    ahb(0, bmbil_pkg::MODE3_OFS, 0);
    chk(rd, {24'h00_0000, w, r, 6'h00});
    ahb(0, bmbil_pkg::MODE13_OFS, 0);
    chk(rd, {26'h000_0000, m, 5'h00});
  endtask : setm
  // Back-to-back write beats; only the first nk are expected to land
  task automatic wburst(bmbil_pkg::bmbil_op_type op, int n, int nk);
    logic [15:0] d;
    logic [1:0] p;
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? 16'h3C7C : 16'($urandom);
      p = (i == 0) ? 2'b00 : 2'($urandom);
      h_req <= 1'b1;
      h_op <= op;
      h_d <= d;
      h_p <= p;
      if (op == bmbil_pkg::OP_WFIFO) tq.push_back(p);
      else if (i < nk) expq.push_back(wexp(op, d, p));
      @(posedge CLK);
    end
    h_req <= 1'b0;
  endtask : wburst
  task automatic drain;
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 60 && expq.size() > 0; i++) @(posedge CLK);
    chk(expq.size(), 0);
  endtask : drain
  task automatic rbeat(bmbil_pkg::bmbil_op_type op, logic [15:0] d);
    logic [15:0] o;
    logic [1:0] p, oe;
    o = d;
    p = 2'b00;
    oe = {2{ri}};
    for (int l = 0; l < 2; l++) if (ri && ones(d[8*l +: 8]) > 4) begin
      o[8*l +: 8] = ~d[8*l +: 8];
      p[l] = 1'b1;
    end
    // Training beats: data passes untouched, pin carries the pattern
    if (op == bmbil_pkg::OP_RFIFO || op == bmbil_pkg::OP_DQCAL) begin
      o = d;
      oe = 2'b11;
      if (op == bmbil_pkg::OP_RFIFO) begin
        p = tq.pop_front();
      end else begin
        p = cp[2*ci +: 2];
        ci = (ci + 1) % 8;
      end
    end
    rd_op <= op;
    RD_VALID <= 1'b1;
    RD_DATA <= d;
    @(negedge CLK);
    chk(RD_READY, 1);
    @(posedge CLK);
    rd_op <= bmbil_pkg::OP_NONE;
    RD_VALID <= 1'b0;
    @(negedge CLK);
    chk(DQ_OUT, o);
    chk({DQ_OE, PIN_OE}, {1'b1, oe});
    if (oe[0]) chk(PIN_OUT, p);
    @(posedge CLK);
  endtask : rbeat
  // ****************************************
  // Clock, timeout and array-side monitor
  // ****************************************
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Stored beats against the oldest expectation; stalls at random
  always @(posedge CLK) begin
    logic [33:0] e;
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
    if (RSTN && ARR_VALID === 1'b1 && ARR_READY === 1'b1 && !train) begin
      e = (expq.size() > 0) ? expq.pop_front() : 34'h3_FFFF_FFFF;
      chk(ARR_BEAT & {e[33:18], 2'b11}, e[17:0]);
    end
    ARR_READY <= stall ? 1'b0 : 1'($urandom_range(1));
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {RSTN, HSEL, HWRITE, h_req, RD_VALID, stall, train, ARR_READY} = 0;
    {HADDR, HWDATA, HTRANS, h_p, h_d, RD_DATA, ri, wi, md} = 0;
    HSIZE = 3'b010;
    {h_op, rd_op} = {2{bmbil_pkg::OP_NONE}};
    void'($urandom(80177));
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    ahb(0, bmbil_pkg::MODE3_OFS, 0);
    chk(rd, bmbil_pkg::MODE3_RST);
    ahb(0, bmbil_pkg::MODE13_OFS, 0);
    chk(rd, bmbil_pkg::MODE13_RST);
    ahb(0, bmbil_pkg::CALPAT_OFS, 0);
    chk(rd, bmbil_pkg::CALPAT_RST);
    ahb(0, 8'h10, 0);
    chk(rd, 0);
    for (int c = 0; c < 8; c++) begin
      setm(c[0], c[1], c[2]);
      rd_op <= bmbil_pkg::OP_WRITE;
      @(negedge CLK);
      if (wi || md) chk(rx_en, wi);
      @(posedge CLK);
      rd_op <= bmbil_pkg::OP_NONE;
      for (int k = 0; k < 9; k++) begin
        wburst(bmbil_pkg::bmbil_op_type'(k % 3 + 1), 2,
               (k % 3 == 1 && md) ? 0 : 2);
        drain();
      end
      ahb(0, bmbil_pkg::STATUS_OFS, 0);
      chk(rd[0], md);
      ahb(1, bmbil_pkg::STATUS_OFS, 32'h0000_0001);
      for (int k = 0; k < 4; k++)
        rbeat(k[0] ? bmbil_pkg::OP_MRR : bmbil_pkg::OP_READ,
              k == 0 ? 16'h1F0F : 16'($urandom));
    end
    // Full buffer with the array stalled: extra beats are refused
    stall = 1'b1;
    @(posedge CLK);
    wburst(bmbil_pkg::OP_WRITE, 4, 2);
    repeat (4) @(posedge CLK);
    chk(ARR_VALID, 1);
    ahb(0, bmbil_pkg::STATUS_OFS, 0);
    chk(rd[1], 1);
    stall = 1'b0;
    drain();
    ahb(1, bmbil_pkg::STATUS_OFS, 32'h0000_0002);
    ahb(0, bmbil_pkg::STATUS_OFS, 0);
    chk(rd, 0);
    // Training: captured pin pattern comes back in order
    train = 1'b1;
    wburst(bmbil_pkg::OP_WFIFO, 8, 0);
    repeat (6) @(posedge CLK);
    for (int k = 0; k < 8; k++)
      rbeat(bmbil_pkg::OP_RFIFO, 16'($urandom));
    // Calibration: pattern register goes out two bits per beat
    cp = 16'($urandom);
    ahb(1, bmbil_pkg::CALPAT_OFS, {16'h0000, cp});
    ahb(0, bmbil_pkg::CALPAT_OFS, 0);
    chk(rd, {16'h0000, cp});
    for (int k = 0; k < 8; k++)
      rbeat(bmbil_pkg::OP_DQCAL, 16'($urandom));
    conclude();
  end
endmodule : tb_byte_mask_bus_inversion_lane
